// >>> xbus_pkg.sv
package xbus_pkg;
  localparam int addr_w = 24;
  localparam int data_w = 16;
  localparam int io_banks = 3;
  localparam int mem_banks = 2;
  localparam int flash_banks = 2;
  localparam int io_bank_bytes = 16384;
  localparam logic [23:0] io_bank_limit = 24'h003fff;
  localparam logic [3:0] strobe_cycles = 4'h2;
  localparam logic [3:0] wait_default = 4'h3;
  localparam logic [7:0] flash_cmd_program = 8'h10;
  localparam logic [7:0] flash_cmd_erase = 8'hd0;
  localparam logic [7:0] flash_cmd_read = 8'h30;

  typedef enum logic [1:0]
  {
    tgt_io = 2'h0,
    tgt_mem = 2'h1,
    tgt_flash = 2'h2
  } target_t;

  typedef enum logic [1:0]
  {
    fl_data = 2'h0,
    fl_cmd = 2'h1,
    fl_addr = 2'h2
  } flash_phase_t;

  typedef struct packed
  {
    target_t target;
    flash_phase_t phase;
    logic [1:0] bank;
    logic write;
    logic [1:0] byte_en;
    logic [23:0] addr;
    logic [15:0] wdata;
  } request_t;

  typedef struct packed
  {
    logic [2:0] io_sel_n;
    logic [1:0] mem_sel_n;
    logic oe_n;
    logic upper_we_n;
    logic lower_we_n;
    logic cle;
    logic ale;
    logic [1:0] fce_n;
    logic fre_n;
    logic fwe_n;
  } strobes_t;
endpackage

// >>> xbus_sync.sv
`timescale 1ns/1ps
module xbus_sync
  import xbus_pkg::*;
#(
  parameter int width = 1
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [width-1:0] d,
  output logic [width-1:0] q
);
  logic [width-1:0] stage_reg;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage_reg <= '1;
      q <= '1;
    end
    else
    begin
      stage_reg <= d;
      q <= stage_reg;
    end
  end
endmodule

// >>> external_memory_io_bus.sv
`timescale 1ns/1ps
// Operation
// - three io banks, each up to 16 KB, one low select per bank
// - io access drives low only the addressed io bank select
// - two rom/sram/nor banks with selects; bank chosen by configured map
// - memory bank 0 or flash bank 0 can be chosen as boot source
// - low external wait stretches the current io or memory access while held
// - shared low output enable driven during reads
// - upper byte write enable low when writing bits 15..8
// - lower byte write enable low for bits 7..0 or full word
// - command latch enable high while a command byte is driven
// - address latch enable high while address bytes are driven
// - two low flash chip enables, only the accessed one asserted
// - low read and write strobes move each flash byte
// - low write protect output blocks flash program and erase
// - each flash bank has own ready/busy; addressed one is sampled
// - 24-bit address bus shared by memory and io accesses
// - bidirectional 16-bit data bus, 8-bit mode, shared with flash
module external_memory_io_bus
  import xbus_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire request_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  input wire logic [3:0] wait_cycles,
  input wire logic mem_swap,
  input wire logic boot_from_flash,
  input wire logic bus_8bit,
  input wire logic write_protect,
  output logic booting_from_flash,
  output logic [23:0] static_address_bus,
  input wire logic [15:0] static_data_in,
  output logic [15:0] static_data_out,
  output logic static_data_oe,
  output logic [2:0] io_bank_selects_n,
  output logic [1:0] mem_bank_selects_n,
  output logic static_output_enable_n,
  output logic upper_byte_write_n,
  output logic lower_byte_write_n,
  output logic flash_cmd_latch_en,
  output logic flash_addr_latch_en,
  output logic flash_bank0_enable_n,
  output logic flash_bank1_enable_n,
  output logic flash_read_strobe_n,
  output logic flash_write_strobe_n,
  output logic flash_write_protect_n,
  input wire logic ext_wait_n,
  input wire logic [1:0] flash_ready_busy_n
);
  typedef enum logic [3:0]
  {
    st_idle = 4'b0001,
    st_strobe = 4'b0010,
    st_hold = 4'b0100,
    st_busy = 4'b1000
  } state_t;

  logic rst_a_reg, rst_n;
  logic wait_n_s;
  logic [1:0] rb_s;
  logic boot_sync;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_a_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_a_reg <= 1'b1;
      rst_n <= rst_a_reg;
    end
  end

  xbus_sync #(.width(4)) u_sync
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .d({ext_wait_n, flash_ready_busy_n, boot_from_flash}),
    .q({wait_n_s, rb_s, boot_sync})
  );

  state_t state_reg, state_next;
  request_t cur_reg, cur_next;
  strobes_t pins_reg, pins_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [23:0] addr_reg, addr_next;
  logic [15:0] dout_reg, dout_next;
  logic doe_reg, doe_next;
  logic rsp_v_reg, rsp_v_next;
  logic [15:0] rdata_reg, rdata_next;
  logic boot_reg, boot_next;
  logic [2:0] boot_done_reg, boot_done_next;
  logic wp_reg;
  logic [1:0] mem_sel;
  logic flash_ready;
  logic busy_cmd;

  strobes_t idle_pins;
  assign idle_pins = '{io_sel_n: 3'h7, mem_sel_n: 2'h3, oe_n: 1'b1,
                       upper_we_n: 1'b1, lower_we_n: 1'b1, cle: 1'b0,
                       ale: 1'b0, fce_n: 2'h3, fre_n: 1'b1, fwe_n: 1'b1};

  // bank map: swap exchanges the two memory banks; the strap is taken only
  // once its synchroniser holds a real sample, not its reset value
  always_comb
  begin
    mem_sel = req.bank[0] ^ mem_swap ? 2'h2 : 2'h1;
    flash_ready = rb_s[cur_reg.bank[0]];
    busy_cmd = cur_reg.phase == fl_cmd && cur_reg.write &&
               (cur_reg.wdata[7:0] == flash_cmd_program ||
                cur_reg.wdata[7:0] == flash_cmd_erase ||
                cur_reg.wdata[7:0] == flash_cmd_read);
  end

  always_comb
  begin
    state_next = state_reg;
    cur_next = cur_reg;
    pins_next = pins_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    dout_next = dout_reg;
    doe_next = doe_reg;
    rsp_v_next = 1'b0;
    rdata_next = rdata_reg;
    boot_next = boot_reg;
    boot_done_next = boot_done_reg;
    if (!boot_done_reg[2])
    begin
      boot_next = boot_done_reg[1] ? boot_sync : boot_reg;
      boot_done_next = {boot_done_reg[1:0], 1'b1};
    end
    unique case (state_reg)
      st_idle:
      begin
        if (req_valid && boot_done_reg[2])
        begin
          cur_next = req;
          cnt_next = (wait_cycles == 4'h0) ? wait_default : wait_cycles;
          pins_next = idle_pins;
          addr_next = req.addr;
          dout_next = bus_8bit ? {8'h00, req.wdata[7:0]} : req.wdata;
          doe_next = req.write;
          unique case (req.target)
            tgt_io:
            begin
              addr_next = req.addr & io_bank_limit;
              if (req.bank < 2'h3)
                pins_next.io_sel_n[req.bank] = 1'b0;
            end
            tgt_mem:
              pins_next.mem_sel_n = ~mem_sel;
            default:
            begin
              cnt_next = strobe_cycles;
              pins_next.fce_n[req.bank[0]] = 1'b0;
              pins_next.cle = req.phase == fl_cmd;
              pins_next.ale = req.phase == fl_addr;
              pins_next.fre_n = req.write;
              pins_next.fwe_n = ~req.write;
            end
          endcase
          if (req.target != tgt_flash)
          begin
            pins_next.oe_n = req.write;
            pins_next.upper_we_n = !(req.write && req.byte_en[1] &&
                                     !bus_8bit);
            pins_next.lower_we_n = !(req.write &&
                                     req.byte_en[0]);
          end
          state_next = st_strobe;
        end
      end
      st_strobe:
      begin
        if (cnt_reg > 4'h1)
          cnt_next = cnt_reg - 4'h1;
        else if (cur_reg.target == tgt_flash || wait_n_s)
        begin
          rdata_next = bus_8bit ? {8'h00, static_data_in[7:0]}
                                : static_data_in;
          pins_next.oe_n = 1'b1;
          pins_next.upper_we_n = 1'b1;
          pins_next.lower_we_n = 1'b1;
          pins_next.fre_n = 1'b1;
          pins_next.fwe_n = 1'b1;
          state_next = st_hold;
        end
      end
      st_hold:
      begin
        pins_next.io_sel_n = 3'h7;
        pins_next.mem_sel_n = 2'h3;
        pins_next.cle = 1'b0;
        pins_next.ale = 1'b0;
        doe_next = 1'b0;
        if (cur_reg.target == tgt_flash && busy_cmd)
        begin
          cnt_next = strobe_cycles;
          state_next = st_busy;
        end
        else
        begin
          pins_next.fce_n = 2'h3;
          rsp_v_next = 1'b1;
          state_next = st_idle;
        end
      end
      st_busy:
      begin
        // ready/busy may lag the command by a few cycles; skip that window
        if (cnt_reg != 4'h0)
          cnt_next = cnt_reg - 4'h1;
        else if (flash_ready)
        begin
          pins_next.fce_n = 2'h3;
          rsp_v_next = 1'b1;
          state_next = st_idle;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= st_idle;
      cur_reg <= '0;
      pins_reg <= '{io_sel_n: 3'h7, mem_sel_n: 2'h3, oe_n: 1'b1,
                    upper_we_n: 1'b1, lower_we_n: 1'b1, cle: 1'b0,
                    ale: 1'b0, fce_n: 2'h3, fre_n: 1'b1, fwe_n: 1'b1};
      cnt_reg <= 4'h0;
      addr_reg <= 24'h000000;
      dout_reg <= 16'h0000;
      doe_reg <= 1'b0;
      rsp_v_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      boot_reg <= 1'b0;
      boot_done_reg <= 3'h0;
      wp_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      pins_reg <= pins_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
      rsp_v_reg <= rsp_v_next;
      rdata_reg <= rdata_next;
      boot_reg <= boot_next;
      boot_done_reg <= boot_done_next;
      wp_reg <= !write_protect;
    end
  end

  // req_ready is registered: high in idle once boot source is latched
  logic ready_reg;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ready_reg <= 1'b0;
    else
      ready_reg <= state_next == st_idle && boot_done_next[2];
  end

  assign req_ready = ready_reg;
  assign rsp_valid = rsp_v_reg;
  assign rsp_rdata = rdata_reg;
  assign booting_from_flash = boot_reg;
  assign static_address_bus = addr_reg;
  assign static_data_out = dout_reg;
  assign static_data_oe = doe_reg;
  assign io_bank_selects_n = pins_reg.io_sel_n;
  assign mem_bank_selects_n = pins_reg.mem_sel_n;
  assign static_output_enable_n = pins_reg.oe_n;
  assign upper_byte_write_n = pins_reg.upper_we_n;
  assign lower_byte_write_n = pins_reg.lower_we_n;
  assign flash_cmd_latch_en = pins_reg.cle;
  assign flash_addr_latch_en = pins_reg.ale;
  assign flash_bank0_enable_n = pins_reg.fce_n[0];
  assign flash_bank1_enable_n = pins_reg.fce_n[1];
  assign flash_read_strobe_n = pins_reg.fre_n;
  assign flash_write_strobe_n = pins_reg.fwe_n;
  assign flash_write_protect_n = wp_reg;
endmodule

// >>> xbus_asserts.sv
`timescale 1ns/1ps
module xbus_asserts
(
  input logic mclk,
  input logic resetn,
  input logic rsp_valid,
  input logic write_protect,
  input logic static_data_oe,
  input logic [2:0] io_bank_selects_n,
  input logic [1:0] mem_bank_selects_n,
  input logic static_output_enable_n,
  input logic upper_byte_write_n,
  input logic lower_byte_write_n,
  input logic flash_bank0_enable_n,
  input logic flash_bank1_enable_n,
  input logic flash_read_strobe_n,
  input logic flash_write_strobe_n,
  input logic flash_write_protect_n,
  input logic ext_wait_n,
  input logic [1:0] flash_ready_busy_n
);
  // outputs stay in reset until the internal synchroniser lets go
  logic [2:0] up_reg;
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
      up_reg <= 3'h0;
    else if (up_reg != 3'h7)
      up_reg <= up_reg + 3'h1;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!resetn || up_reg != 3'h7);
  io_one_a: assert property ($countones(~io_bank_selects_n) <= 1)
    else $error("two io selects");
  io_alone_a: assert property (!(&io_bank_selects_n) |->
    &mem_bank_selects_n && flash_bank0_enable_n && flash_bank1_enable_n)
    else $error("io select with other");
  flash_one_a: assert property (
    flash_bank0_enable_n || flash_bank1_enable_n)
    else $error("two flash enables");
  wp_lag_a: assert property (
    flash_write_protect_n == !$past(write_protect))
    else $error("protect not following");
  read_oe_a: assert property (!static_output_enable_n |->
    !static_data_oe && lower_byte_write_n && upper_byte_write_n)
    else $error("drive during read");
  write_drive_a: assert property (
    !(lower_byte_write_n && upper_byte_write_n) |->
    static_data_oe && static_output_enable_n)
    else $error("write without drive");
  wait_hold_a: assert property (
    (!static_output_enable_n && !ext_wait_n) [*4] |=> !static_output_enable_n)
    else $error("ended under wait");
  busy_quiet_a: assert property ((!flash_ready_busy_n[0]) [*3] |->
    flash_write_strobe_n && flash_read_strobe_n && !rsp_valid)
    else $error("activity while busy");
  cover property (!(&io_bank_selects_n));
  cover property ((!static_output_enable_n && !ext_wait_n) [*4]);
  cover property ((!flash_ready_busy_n[0]) [*3]);
endmodule

bind external_memory_io_bus xbus_asserts xbus_asserts_inst (.*);

// >>> xbus_partner_model.sv
`timescale 1ns/1ps
module xbus_partner_model
  import xbus_pkg::*;
#(
  parameter int busy_len = 6
)
(
  input logic mclk,
  input logic [23:0] static_address_bus,
  input logic [15:0] static_data_out,
  input logic [1:0] mem_bank_selects_n,
  input logic static_output_enable_n,
  input logic upper_byte_write_n,
  input logic lower_byte_write_n,
  input logic flash_cmd_latch_en,
  input logic flash_bank0_enable_n,
  input logic flash_write_strobe_n,
  output logic [15:0] static_data_in,
  output logic ext_wait_n,
  output logic [1:0] flash_ready_busy_n
);
  logic [15:0] mem [16];
  logic [15:0] last = 16'h0000;
  logic [3:0] a;
  logic fwe_q, bank1;
  int wcnt = 0;
  int bcnt = 0;
  assign a = static_address_bus[3:0];
  // bank 1 is a slow part: wait held for its first 8 cycles
  assign ext_wait_n = !(!mem_bank_selects_n[1] && wcnt < 8);
  assign flash_ready_busy_n = (bcnt == 0) ? 2'h3 :
    (bank1 ? 2'h1 : 2'h2);
  // released bus shows the inverse of its last value, never a stale match
  assign static_data_in = static_output_enable_n ? ~last : mem[a];
  always @(posedge mclk)
  begin
    last <= static_data_in;
    fwe_q <= flash_write_strobe_n;
    wcnt <= mem_bank_selects_n[1] ? 0 : wcnt + 1;
    if (bcnt > 0)
      bcnt <= bcnt - 1;
    if (!lower_byte_write_n)
      mem[a][7:0] <= static_data_out[7:0];
    if (!upper_byte_write_n)
      mem[a][15:8] <= static_data_out[15:8];
    if (flash_write_strobe_n && !fwe_q && flash_cmd_latch_en &&
      static_data_out[7:0] inside {flash_cmd_program, flash_cmd_erase,
      flash_cmd_read})
    begin
      bcnt <= busy_len;
      bank1 <= flash_bank0_enable_n;
    end
  end
endmodule

// >>> external_memory_io_bus_tb.sv
`timescale 1ns/1ps
module external_memory_io_bus_tb;
  import xbus_pkg::*;
  localparam int busy_len = 6;
  logic mclk = 1'b0, resetn = 1'b0, req_valid = 1'b0;
  logic mem_swap = 1'b0, bus_8bit = 1'b0, write_protect = 1'b0;
  logic boot_from_flash = 1'b1;
  logic [3:0] wait_cycles = 4'h0;
  request_t req = '0;
  logic req_ready, rsp_valid, booting_from_flash, static_data_oe;
  logic [15:0] rsp_rdata, static_data_in, static_data_out;
  logic [23:0] static_address_bus, s_addr;
  logic [2:0] io_bank_selects_n, s_io;
  logic [1:0] mem_bank_selects_n, flash_ready_busy_n, s_mem, s_fce;
  logic static_output_enable_n, upper_byte_write_n, lower_byte_write_n;
  logic flash_cmd_latch_en, flash_addr_latch_en, flash_bank0_enable_n;
  logic flash_bank1_enable_n, flash_read_strobe_n, flash_write_strobe_n;
  logic flash_write_protect_n, ext_wait_n, s_uwe, s_cle, s_ale, s_fre;
  int errors = 0, compares = 0, lat = 0;

  external_memory_io_bus external_memory_io_bus_inst (.*);
  xbus_partner_model #(.busy_len(busy_len)) xbus_partner_model_inst (.*);

  always #5 mclk = ~mclk;

  // sticky record of what the bus did during one access
  always @(posedge mclk)
  begin
    s_io <= s_io | ~io_bank_selects_n;
    s_mem <= s_mem | ~mem_bank_selects_n;
    s_fce <= s_fce | ~{flash_bank1_enable_n, flash_bank0_enable_n};
    s_uwe <= s_uwe | ~upper_byte_write_n;
    s_cle <= s_cle | flash_cmd_latch_en;
    s_ale <= s_ale | flash_addr_latch_en;
    s_fre <= s_fre | ~flash_read_strobe_n;
    if (!(&io_bank_selects_n))
      s_addr <= static_address_bus;
    lat <= lat + 1;
  end

  task automatic chk(logic [23:0] got, logic [23:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic go(target_t t, flash_phase_t p, logic [1:0] b, logic w,
    logic [1:0] be, logic [23:0] a, logic [15:0] d);
    int n;
    n = 0;
    {s_io, s_mem, s_fce, s_uwe, s_cle, s_ale, s_fre} = '0;
    lat = 0;
    req = '{t, p, b, w, be, a, d};
    req_valid = 1'b1;
    do @(posedge mclk); while (req_ready !== 1'b1 && ++n < 50);
    #1 req_valid = 1'b0;
    do @(posedge mclk); while (rsp_valid !== 1'b1 && ++n < 200);
    #1 chk(n < 200, 1'b1);
  endtask

  task automatic t_boot_wp();
    chk(booting_from_flash, 1'b1);
    write_protect = 1'b1;
    repeat (3) @(posedge mclk);
    #1 chk(flash_write_protect_n, 1'b0);
    write_protect = 1'b0;
  endtask

  task automatic t_mem();
    go(tgt_mem, fl_data, 2'h0, 1'b1, 2'h3, 24'h000004, 16'ha55a);
    chk(s_mem, 2'h1);
    go(tgt_mem, fl_data, 2'h0, 1'b1, 2'h2, 24'h000004, 16'h3cc3);
    go(tgt_mem, fl_data, 2'h0, 1'b0, 2'h3, 24'h000004, 16'h0000);
    chk(rsp_rdata, 16'h3c5a);
    mem_swap = 1'b1;
    // swapped bank 0 lands on the slow part, so wait must stretch it
    go(tgt_mem, fl_data, 2'h0, 1'b0, 2'h3, 24'h000004, 16'h0000);
    chk(s_mem, 2'h2);
    chk(lat > 10, 1'b1);
    mem_swap = 1'b0;
    // programmed count of 8 on a fast part: take edge plus 8 plus 2
    wait_cycles = 4'h8;
    go(tgt_mem, fl_data, 2'h0, 1'b0, 2'h3, 24'h000004, 16'h0000);
    chk(24'(lat), 24'd11);
    wait_cycles = 4'h0;
    bus_8bit = 1'b1;
    go(tgt_mem, fl_data, 2'h0, 1'b1, 2'h3, 24'h000005, 16'hbeef);
    chk(s_uwe, 1'b0);
    go(tgt_mem, fl_data, 2'h0, 1'b0, 2'h3, 24'h000005, 16'h0000);
    chk(rsp_rdata, 16'h00ef);
    bus_8bit = 1'b0;
  endtask

  task automatic t_io();
    for (int b = 0; b < 3; b++)
    begin
      logic [23:0] a;
      a = 24'h00c008 + 24'(b);
      go(tgt_io, fl_data, 2'(b), 1'b1, 2'h3, a, 16'h1111 * 16'(b + 1));
      chk(s_io, 3'h1 << b);
      chk(s_addr, a & io_bank_limit);
      go(tgt_io, fl_data, 2'(b), 1'b0, 2'h3, a, 16'h0000);
      chk(rsp_rdata, 16'h1111 * 16'(b + 1));
    end
  endtask

  task automatic t_flash();
    go(tgt_flash, fl_cmd, 2'h1, 1'b1, 2'h0, 24'h0, 16'h0070);
    chk({s_fce, s_cle, s_ale}, 4'ha);
    go(tgt_flash, fl_addr, 2'h1, 1'b1, 2'h0, 24'h0, 16'h0012);
    chk({s_fce, s_cle, s_ale}, 4'h9);
    go(tgt_flash, fl_cmd, 2'h0, 1'b1, 2'h0, 24'h0, {8'h00, flash_cmd_read});
    chk(s_fce, 2'h1);
    chk(lat > busy_len + 4, 1'b1);
    go(tgt_flash, fl_data, 2'h0, 1'b0, 2'h0, 24'h0, 16'h0000);
    chk(s_fre, 1'b1);
  endtask

  task automatic t_reset();
    resetn = 1'b0;
    boot_from_flash = 1'b0;
    repeat (6) @(posedge mclk);
    #1 chk(req_ready, 1'b0);
    resetn = 1'b1;
    repeat (8) @(posedge mclk);
    #1 chk(booting_from_flash, 1'b0);
    chk(req_ready, 1'b1);
  endtask

  task automatic final_report();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge mclk);
    #1 resetn = 1'b1;
    repeat (8) @(posedge mclk);
    #1 t_boot_wp();
    t_mem();
    t_io();
    t_flash();
    t_reset();
    final_report();
  end

  // the run needs about 150 cycles; over twenty times that means a hang
  initial
  begin
    #40000;
    errors++;
    $display("ERROR %0t: timeout", $time);
    final_report();
  end
endmodule
